// ===== hpsp_host.sv
// Management bus host model that clocks the bus and pulls the data line low
`timescale 1ns/1ps
module hpsp_host (
  input  wire logic ref_clk,
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Data moves only while the bus clock is low, so a start or stop is never faked
  task automatic put_bit(input logic b);
    sda_low = !b;
    tick(3);
    scl = 1'b1;
    tick(3);
    scl = 1'b0;
    tick(1);
  endtask
  task automatic get_bit(output logic b);
    sda_low = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(1);
    b = sda;
    tick(2);
    scl = 1'b0;
    tick(1);
  endtask
  task automatic start();
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(3);
    sda_low = 1'b1;
    tick(3);
    scl = 1'b0;
    tick(1);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(3);
    sda_low = 1'b0;
    tick(3);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = !b;
  endtask
  // Single data byte only; the host always ends a read with a not-acknowledge
  task automatic get_byte(output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(1'b1);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] d, output logic [2:0] ack);
    start();
    put_byte({a, 1'b0}, ack[2]);
    put_byte(cmd, ack[1]);
    put_byte(d, ack[0]);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] cmd, output logic [7:0] d, output logic [2:0] ack);
    start();
    put_byte({a, 1'b0}, ack[2]);
    put_byte(cmd, ack[1]);
    start();
    put_byte({a, 1'b1}, ack[0]);
    get_byte(d);
    stop();
  endtask
endmodule

// ===== hpsp_line_if.sv
// Bus line events passed from the line sensor to the transaction engine
`timescale 1ns/1ps
interface hpsp_line_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;
  modport sense (output scl_rise, output scl_fall, output start, output stop, output sda);
  modport engine (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface

// ===== hpsp_line_sense.sv
// Edge, start and stop detection on the management bus lines
`timescale 1ns/1ps
module hpsp_line_sense
  import hpsp_pkg::*;
(
  input  wire logic    ref_clk,
  input  wire logic    nrst,
  input  wire logic    scl_i,
  input  wire logic    sda_i,
  hpsp_line_if.sense   ln
);
  logic scl_reg;
  logic scl_next;
  logic sda_reg;
  logic sda_next;

  always_comb begin
    scl_next = scl_i;
    sda_next = sda_i;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= scl_next;
      sda_reg <= sda_next;
    end
  end

  // Lines are taken as synchronous, so one stage of history is enough
  assign ln.scl_rise = scl_i & ~scl_reg;
  assign ln.scl_fall = ~scl_i & scl_reg;
  assign ln.start    = scl_i & scl_reg & sda_reg & ~sda_i;
  assign ln.stop     = scl_i & scl_reg & ~sda_reg & sda_i;
  assign ln.sda      = sda_i;
endmodule

// ===== hpsp_pkg.sv
// Constants, register map and state codes of the hot plug slot power register bank
package hpsp_pkg;
  localparam logic [7:0] HPSP_OFS_RESULT   = 8'h00;
  localparam logic [7:0] HPSP_OFS_ADC_CTRL = 8'h01;
  localparam logic [7:0] HPSP_OFS_CTRL_A   = 8'h02;
  localparam logic [7:0] HPSP_OFS_CTRL_B   = 8'h03;
  localparam logic [7:0] HPSP_OFS_STAT_A   = 8'h04;

  localparam logic [7:0] HPSP_RST_CTRL     = 8'h00;
  localparam logic [7:0] HPSP_RST_STAT     = 8'h00;
  localparam logic [7:0] HPSP_RST_ADC      = 8'h00;
  localparam logic [7:0] HPSP_RST_RESULT   = 8'h00;

  localparam int HPSP_CTRL_AUX_ON_BIT  = 0;
  localparam int HPSP_CTRL_MAIN_ON_BIT = 1;
  localparam int HPSP_CTRL_MAIN_GD_BIT = 6;
  localparam int HPSP_CTRL_AUX_GD_BIT  = 7;

  localparam int HPSP_STAT_OC_MSB      = 4;
  localparam int HPSP_STAT_OC_AUX_BIT  = 4;
  localparam int HPSP_STAT_AUX_BIT     = 5;
  localparam int HPSP_STAT_MAIN_BIT    = 6;
  localparam int HPSP_STAT_TRIP_BIT    = 7;

  localparam int HPSP_ADC_FIELD_MSB    = 4;
  localparam int HPSP_ADC_SLOT_BIT     = 4;
  localparam int HPSP_ADC_QUANT_BIT    = 3;
  localparam int HPSP_ADC_RAIL_MSB     = 2;
  localparam int HPSP_ADC_BUSY_BIT     = 7;
  localparam logic [2:0] HPSP_RAIL_NONE = 3'h0;

  localparam logic [3:0] HPSP_SMB_ADDR_PREFIX = 4'h8;
  localparam logic [3:0] HPSP_BITS_PER_BYTE   = 4'h8;

  localparam longint HPSP_CLK_HZ       = 200_000_000;
  localparam longint HPSP_CONV_TIME_MS = 100;
  localparam int     HPSP_CONV_CYCLES  = int'((HPSP_CONV_TIME_MS * HPSP_CLK_HZ) / 1000);
  localparam int     HPSP_CONV_CNT_W   = 25;

  typedef enum logic [3:0] {
    HPSP_IDLE      = 4'b0000,
    HPSP_ADDR      = 4'b0001,
    HPSP_ADDR_ACK  = 4'b0010,
    HPSP_CMD       = 4'b0011,
    HPSP_CMD_ACK   = 4'b0100,
    HPSP_WDATA     = 4'b0101,
    HPSP_WDATA_ACK = 4'b0110,
    HPSP_RDATA     = 4'b0111,
    HPSP_RDATA_ACK = 4'b1000,
    HPSP_IGNORE    = 4'b1001
  } hpsp_state_e;
endpackage

// ===== hpsp_regs.sv
// Byte-wide management bus slave with slot power control, slot A status and measurement control
// Summary of operation
// - Host waits the conversion time or polls busy; result is then valid.
// - Slot A control: bit1 main enable, bit0 aux enable, bits7:6 good, rest zero.
// - Good flags follow aux output or all main outputs above undervoltage threshold.
// - Slot A control clears to zero at reset, all slot A outputs off.
// - Slot B control has the same layout as slot A.
// - Slot B control clears to zero at reset, all slot B outputs off.
// - Slot A status: bits7:5 read-only pin and output states, bits4:0 overcurrent flags.
// - Main status bit shows the actual state of the four main outputs.
// - Aux status bit shows the actual state of the auxiliary output.
// - Overcurrent flags for aux, -12V, +12V, 5V, 3.3V set on a supply fault.
// - Writing one clears a flag; interrupt releases when no flag remains.
// - Trip pin status bit reads one while the active-low trip pin is low.
// - Under bus power path control the trip status bit and pin stay inactive.
// - Registers are reached only by single-byte read and write bus transactions.
`timescale 1ns/1ps
module hpsp_regs
  import hpsp_pkg::*;
#(
  parameter int CONV_CYCLES = HPSP_CONV_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic [2:0] addr_strap,
  input  wire logic       slot_a_aux_good,
  input  wire logic       slot_a_main_good,
  input  wire logic       slot_b_aux_good,
  input  wire logic       slot_b_main_good,
  input  wire logic       slot_a_main_state,
  input  wire logic       slot_a_aux_state,
  input  wire logic [4:0] slot_a_oc_event,
  input  wire logic       slot_a_bus_path,
  input  wire logic       slot_a_on_pin,
  input  wire logic       slot_a_auxen_pin,
  input  wire logic       slot_a_trip_pin_i,
  output logic            slot_a_trip_pin_o,
  output logic            slot_a_trip_pin_oe,
  output logic            int_n,
  output logic            slot_a_main_on,
  output logic            slot_a_aux_on,
  output logic            slot_b_main_on,
  output logic            slot_b_aux_on,
  output logic            adc_slot_choice,
  output logic            adc_quantity_choice,
  output logic [2:0]      adc_rail_choice,
  output logic            adc_start,
  input  wire logic [7:0] adc_code
);
  hpsp_line_if ln ();

  hpsp_line_sense u_sense (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .ln      (ln)
  );

  hpsp_state_e               st_reg;
  hpsp_state_e               st_next;
  logic [3:0]                cnt_reg;
  logic [3:0]                cnt_next;
  logic [7:0]                sh_reg;
  logic [7:0]                sh_next;
  logic [7:0]                cmd_reg;
  logic [7:0]                cmd_next;
  logic                      rw_reg;
  logic                      rw_next;
  logic                      oe_reg;
  logic                      oe_next;
  logic [2:0]                strap_reg;
  logic [2:0]                strap_next;
  logic                      strap_taken_reg;
  logic                      strap_taken_next;
  logic                      wr_go;
  logic [7:0]                rd_val;

  logic [1:0]                ctrl_a_reg;
  logic [1:0]                ctrl_a_next;
  logic [1:0]                ctrl_b_reg;
  logic [1:0]                ctrl_b_next;
  logic [4:0]                oc_reg;
  logic [4:0]                oc_next;
  logic                      int_n_reg;
  logic                      int_n_next;
  logic                      trip_main_reg;
  logic                      trip_main_next;
  logic                      trip_aux_reg;
  logic                      trip_aux_next;
  logic                      trip_oe_reg;
  logic                      trip_oe_next;
  logic [4:0]                adc_reg;
  logic [4:0]                adc_next;
  logic                      busy_reg;
  logic                      busy_next;
  logic [HPSP_CONV_CNT_W-1:0] conv_reg;
  logic [HPSP_CONV_CNT_W-1:0] conv_next;
  logic [7:0]                result_reg;
  logic [7:0]                result_next;
  logic                      start_reg;
  logic                      start_next;

  localparam logic [HPSP_CONV_CNT_W-1:0] CONV_LAST = HPSP_CONV_CNT_W'(CONV_CYCLES - 1);

  // Read view of every mapped register; unmapped commands read as zero
  function automatic logic [7:0] rd_byte(input logic [7:0] cmd);
    logic [7:0] v;
    v = 8'h00;
    unique case (cmd)
      HPSP_OFS_RESULT:   v = result_reg;
      HPSP_OFS_ADC_CTRL: v = {busy_reg, 2'b00, adc_reg};
      HPSP_OFS_CTRL_A:   v = {slot_a_aux_good, slot_a_main_good, 4'h0, ctrl_a_reg};
      HPSP_OFS_CTRL_B:   v = {slot_b_aux_good, slot_b_main_good, 4'h0, ctrl_b_reg};
      HPSP_OFS_STAT_A:   v = {~slot_a_trip_pin_i & ~slot_a_bus_path,
                              slot_a_main_state, slot_a_aux_state, oc_reg};
      default:           v = 8'h00;
    endcase
    return v;
  endfunction

  // Write strobe decode, used by every register group
  function automatic logic wr_hit(input logic go, input logic [7:0] cmd, input logic [7:0] ofs);
    return go && (cmd == ofs);
  endfunction

  // Process form: a plain assign would miss changes of registers read inside the function
  always_comb rd_val = rd_byte(cmd_reg);

  // Strap is caught once, in the first cycle after reset release
  always_comb begin
    strap_next       = strap_reg;
    strap_taken_next = 1'b1;
    if (!strap_taken_reg) begin
      strap_next = addr_strap;
    end
  end

  // Byte transaction engine: address, command, one data byte
  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    sh_next  = sh_reg;
    cmd_next = cmd_reg;
    rw_next  = rw_reg;
    oe_next  = oe_reg;
    wr_go    = 1'b0;
    if (ln.stop) begin
      st_next = HPSP_IDLE;
      oe_next = 1'b0;
    end else if (ln.start) begin
      st_next  = HPSP_ADDR;
      cnt_next = 4'h0;
      oe_next  = 1'b0;
    end else if (ln.scl_rise) begin
      if (st_reg == HPSP_ADDR || st_reg == HPSP_CMD || st_reg == HPSP_WDATA) begin
        sh_next  = {sh_reg[6:0], ln.sda};
        cnt_next = cnt_reg + 4'h1;
      end else if (st_reg == HPSP_RDATA) begin
        cnt_next = cnt_reg + 4'h1;
      end
    end else if (ln.scl_fall) begin
      unique case (st_reg)
        HPSP_IDLE, HPSP_IGNORE: begin
          st_next = st_reg;
        end
        HPSP_ADDR: begin
          if (cnt_reg == HPSP_BITS_PER_BYTE) begin
            if (sh_reg[7:1] == {HPSP_SMB_ADDR_PREFIX, strap_reg}) begin
              st_next = HPSP_ADDR_ACK;
              rw_next = sh_reg[0];
              oe_next = 1'b1;
            end else begin
              st_next = HPSP_IGNORE;
            end
          end
        end
        HPSP_ADDR_ACK: begin
          cnt_next = 4'h0;
          if (rw_reg) begin
            st_next = HPSP_RDATA;
            sh_next = rd_val;
            oe_next = ~rd_val[7];
          end else begin
            st_next = HPSP_CMD;
            oe_next = 1'b0;
          end
        end
        HPSP_CMD: begin
          if (cnt_reg == HPSP_BITS_PER_BYTE) begin
            cmd_next = sh_reg;
            st_next  = HPSP_CMD_ACK;
            oe_next  = 1'b1;
          end
        end
        HPSP_CMD_ACK: begin
          cnt_next = 4'h0;
          st_next  = HPSP_WDATA;
          oe_next  = 1'b0;
        end
        HPSP_WDATA: begin
          if (cnt_reg == HPSP_BITS_PER_BYTE) begin
            wr_go   = 1'b1;
            st_next = HPSP_WDATA_ACK;
            oe_next = 1'b1;
          end
        end
        HPSP_WDATA_ACK: begin
          // Further bytes are not acknowledged: single-byte access only
          st_next = HPSP_IGNORE;
          oe_next = 1'b0;
        end
        HPSP_RDATA: begin
          if (cnt_reg == HPSP_BITS_PER_BYTE) begin
            st_next = HPSP_RDATA_ACK;
            oe_next = 1'b0;
          end else begin
            sh_next = {sh_reg[6:0], 1'b0};
            oe_next = ~sh_reg[6];
          end
        end
        HPSP_RDATA_ACK: begin
          st_next = HPSP_IGNORE;
        end
        default: begin
          st_next = HPSP_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  // Slot power control and slot A status
  always_comb begin
    ctrl_a_next    = ctrl_a_reg;
    ctrl_b_next    = ctrl_b_reg;
    oc_next        = oc_reg;
    trip_main_next = trip_main_reg;
    trip_aux_next  = trip_aux_reg;
    if (wr_hit(wr_go, cmd_reg, HPSP_OFS_CTRL_A)) begin
      ctrl_a_next = sh_reg[HPSP_CTRL_MAIN_ON_BIT:HPSP_CTRL_AUX_ON_BIT];
    end
    if (wr_hit(wr_go, cmd_reg, HPSP_OFS_CTRL_B)) begin
      ctrl_b_next = sh_reg[HPSP_CTRL_MAIN_ON_BIT:HPSP_CTRL_AUX_ON_BIT];
    end
    if (wr_hit(wr_go, cmd_reg, HPSP_OFS_STAT_A)) begin
      oc_next = oc_reg & ~sh_reg[HPSP_STAT_OC_MSB:0];
    end
    // A fault landing in the clearing cycle is kept
    oc_next = oc_next | slot_a_oc_event;
    // Trip latch is released by dropping the matching enable pin or by bus power path control
    if (!slot_a_on_pin) begin
      trip_main_next = 1'b0;
    end
    if (!slot_a_auxen_pin) begin
      trip_aux_next = 1'b0;
    end
    if (!slot_a_bus_path) begin
      trip_main_next = trip_main_next | (|slot_a_oc_event[HPSP_STAT_OC_AUX_BIT-1:0]);
      trip_aux_next  = trip_aux_next | slot_a_oc_event[HPSP_STAT_OC_AUX_BIT];
    end else begin
      trip_main_next = 1'b0;
      trip_aux_next  = 1'b0;
    end
    trip_oe_next = trip_main_next | trip_aux_next;
    int_n_next   = ~(|oc_next);
  end

  // Measurement control: a write naming a supply starts a timed conversion
  always_comb begin
    adc_next    = adc_reg;
    busy_next   = busy_reg;
    conv_next   = conv_reg;
    result_next = result_reg;
    start_next  = 1'b0;
    if (busy_reg) begin
      if (conv_reg == CONV_LAST) begin
        busy_next   = 1'b0;
        result_next = adc_code;
      end else begin
        conv_next = conv_reg + HPSP_CONV_CNT_W'(1);
      end
    end
    if (wr_hit(wr_go, cmd_reg, HPSP_OFS_ADC_CTRL)) begin
      adc_next = sh_reg[HPSP_ADC_FIELD_MSB:0];
      // A rewrite naming a supply mid-conversion restarts it; one naming no supply leaves the running conversion to finish
      if (sh_reg[HPSP_ADC_RAIL_MSB:0] != HPSP_RAIL_NONE) begin
        busy_next  = 1'b1;
        conv_next  = '0;
        start_next = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_reg          <= HPSP_IDLE;
      cnt_reg         <= 4'h0;
      sh_reg          <= 8'h00;
      cmd_reg         <= 8'h00;
      rw_reg          <= 1'b0;
      oe_reg          <= 1'b0;
      strap_reg       <= 3'h0;
      strap_taken_reg <= 1'b0;
      ctrl_a_reg      <= HPSP_RST_CTRL[1:0];
      ctrl_b_reg      <= HPSP_RST_CTRL[1:0];
      oc_reg          <= HPSP_RST_STAT[4:0];
      int_n_reg       <= 1'b1;
      trip_main_reg   <= 1'b0;
      trip_aux_reg    <= 1'b0;
      trip_oe_reg     <= 1'b0;
      adc_reg         <= HPSP_RST_ADC[4:0];
      busy_reg        <= 1'b0;
      conv_reg        <= '0;
      result_reg      <= HPSP_RST_RESULT;
      start_reg       <= 1'b0;
    end else begin
      st_reg          <= st_next;
      cnt_reg         <= cnt_next;
      sh_reg          <= sh_next;
      cmd_reg         <= cmd_next;
      rw_reg          <= rw_next;
      oe_reg          <= oe_next;
      strap_reg       <= strap_next;
      strap_taken_reg <= strap_taken_next;
      ctrl_a_reg      <= ctrl_a_next;
      ctrl_b_reg      <= ctrl_b_next;
      oc_reg          <= oc_next;
      int_n_reg       <= int_n_next;
      trip_main_reg   <= trip_main_next;
      trip_aux_reg    <= trip_aux_next;
      trip_oe_reg     <= trip_oe_next;
      adc_reg         <= adc_next;
      busy_reg        <= busy_next;
      conv_reg        <= conv_next;
      result_reg      <= result_next;
      start_reg       <= start_next;
    end
  end

  // Open-drain lines only ever pull low
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sda_o             <= 1'b0;
      slot_a_trip_pin_o <= 1'b0;
    end else begin
      sda_o             <= 1'b0;
      slot_a_trip_pin_o <= 1'b0;
    end
  end

  assign sda_oe              = oe_reg;
  assign slot_a_trip_pin_oe  = trip_oe_reg;
  assign int_n               = int_n_reg;
  assign slot_a_main_on      = ctrl_a_reg[HPSP_CTRL_MAIN_ON_BIT];
  assign slot_a_aux_on       = ctrl_a_reg[HPSP_CTRL_AUX_ON_BIT];
  assign slot_b_main_on      = ctrl_b_reg[HPSP_CTRL_MAIN_ON_BIT];
  assign slot_b_aux_on       = ctrl_b_reg[HPSP_CTRL_AUX_ON_BIT];
  assign adc_slot_choice     = adc_reg[HPSP_ADC_SLOT_BIT];
  assign adc_quantity_choice = adc_reg[HPSP_ADC_QUANT_BIT];
  assign adc_rail_choice     = adc_reg[HPSP_ADC_RAIL_MSB:0];
  assign adc_start           = start_reg;
endmodule

// ===== hpsp_regs_chk.sv
// Concurrent checks on the slot power register bank ports
`timescale 1ns/1ps
module hpsp_regs_chk
  import hpsp_pkg::*;
#(
  parameter int CONV_CYCLES = HPSP_CONV_CYCLES
) (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic [4:0] slot_a_oc_event,
  input wire logic       slot_a_bus_path,
  input wire logic       slot_a_on_pin,
  input wire logic       slot_a_auxen_pin,
  input wire logic       slot_a_trip_pin_oe,
  input wire logic       int_n,
  input wire logic       slot_a_main_on,
  input wire logic       slot_a_aux_on,
  input wire logic       slot_b_main_on,
  input wire logic       slot_b_aux_on,
  input wire logic [2:0] adc_rail_choice,
  input wire logic       adc_start
);
  logic [3:0] ens;
  logic       pin_mode;
  assign ens = {slot_a_main_on, slot_a_aux_on, slot_b_main_on, slot_b_aux_on};
  // Trip latch is only armed while the pins, not the bus, own the power paths
  assign pin_mode = !slot_a_bus_path && slot_a_on_pin && slot_a_auxen_pin;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_reset_all_off: assert property ($rose(nrst) |-> ens == 4'h0 && int_n && !adc_start && !slot_a_trip_pin_oe)
    else $error("outputs not off after reset");
  a_data_drive_low: assert property (sda_oe |-> !sda_o)
    else $error("data line driven high");
  a_data_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data line moved while bus clock high");
  a_enable_by_write: assert property (!$stable(ens) |-> sda_oe || $past(sda_oe))
    else $error("enable changed outside a write");
  a_event_sets_int: assert property (|slot_a_oc_event |-> ##[1:2] !int_n)
    else $error("overcurrent did not raise interrupt");
  a_int_clear_write: assert property ($rose(int_n) |-> sda_oe || $past(sda_oe))
    else $error("interrupt released without a write");
  a_trip_on_event: assert property (pin_mode && |slot_a_oc_event |=> slot_a_trip_pin_oe)
    else $error("trip pin not pulled on overcurrent");
  a_trip_held: assert property (pin_mode && slot_a_trip_pin_oe |=> slot_a_trip_pin_oe)
    else $error("trip pin released while enables high");
  a_bus_path_quiet: assert property (slot_a_bus_path && $past(slot_a_bus_path) |-> !slot_a_trip_pin_oe)
    else $error("trip pin active under bus control");
  a_start_one_cycle: assert property (adc_start |=> !adc_start)
    else $error("conversion start longer than one cycle");
  a_start_needs_rail: assert property (adc_start |-> adc_rail_choice != HPSP_RAIL_NONE)
    else $error("conversion started with no supply chosen");
  a_start_by_write: assert property (adc_start |-> sda_oe || $past(sda_oe))
    else $error("conversion started outside a write");
  c_adc_start: cover property (adc_start);
  c_int_low: cover property ($fell(int_n));
  c_slot_b_on: cover property ($rose(slot_b_main_on));
  c_trip: cover property (slot_a_trip_pin_oe);
endmodule

bind hpsp_regs hpsp_regs_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.ref_clk, .nrst, .scl_i, .sda_o, .sda_oe,
  .slot_a_oc_event, .slot_a_bus_path, .slot_a_on_pin, .slot_a_auxen_pin, .slot_a_trip_pin_oe, .int_n,
  .slot_a_main_on, .slot_a_aux_on, .slot_b_main_on, .slot_b_aux_on, .adc_rail_choice, .adc_start);

// ===== tb_top.sv
// Self-checking bench for the slot power register bank
`timescale 1ns/1ps
module tb_top;
  import hpsp_pkg::*;
  // Long enough that the first read after a start still sees busy
  localparam int         CONV  = 360;
  localparam int         LIMIT = 40000;
  localparam logic [6:0] DEV   = {HPSP_SMB_ADDR_PREFIX, 3'h5};
  logic       ref_clk, nrst, scl, h_low, sda_o, sda_oe, trip_o, trip_oe, ext_trip_low, int_n;
  logic       a_ag, a_mg, b_ag, b_mg, a_mst, a_xst, bus_path, on_pin, auxen_pin, adc_start;
  logic       a_mon, a_xon, b_mon, b_xon, adc_slot, adc_qty;
  logic [2:0] adc_rail, acks;
  logic [4:0] oc_ev;
  logic [7:0] adc_code, rdat;
  int         bad_count, n_compared, cyc, starts;
  wire        sda_w  = !(h_low | (sda_oe === 1'b1 && sda_o === 1'b0));
  wire        trip_w = !(ext_trip_low | (trip_oe === 1'b1 && trip_o === 1'b0));
  wire [7:0]  outs   = {a_mon, a_xon, b_mon, b_xon, int_n, trip_oe, adc_qty, adc_slot};

  hpsp_regs #(.CONV_CYCLES(CONV)) dut (.ref_clk(ref_clk), .nrst(nrst), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap(3'h5), .slot_a_aux_good(a_ag), .slot_a_main_good(a_mg),
    .slot_b_aux_good(b_ag), .slot_b_main_good(b_mg), .slot_a_main_state(a_mst), .slot_a_aux_state(a_xst),
    .slot_a_oc_event(oc_ev), .slot_a_bus_path(bus_path), .slot_a_on_pin(on_pin), .slot_a_auxen_pin(auxen_pin),
    .slot_a_trip_pin_i(trip_w), .slot_a_trip_pin_o(trip_o), .slot_a_trip_pin_oe(trip_oe), .int_n(int_n),
    .slot_a_main_on(a_mon), .slot_a_aux_on(a_xon), .slot_b_main_on(b_mon), .slot_b_aux_on(b_xon),
    .adc_slot_choice(adc_slot), .adc_quantity_choice(adc_qty), .adc_rail_choice(adc_rail),
    .adc_start(adc_start), .adc_code(adc_code));
  hpsp_host host (.ref_clk(ref_clk), .scl(scl), .sda_low(h_low), .sda(sda_w));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (adc_start === 1'b1) starts <= starts + 1;
    if (cyc == LIMIT) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      bad_count++;
    end
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    host.wr(DEV, cmd, d, acks);
    check({5'h00, acks}, 8'h07);
  endtask
  task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
    host.rd(DEV, cmd, rdat, acks);
    check({5'h00, acks}, 8'h07);
    check(rdat, exp);
  endtask
  task automatic ev(input logic [4:0] m);
    oc_ev = m;
    @(negedge ref_clk);
    oc_ev = 5'h00;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    {nrst, a_ag, a_mg, b_ag, b_mg, a_mst, a_xst, on_pin, auxen_pin, ext_trip_low} = 10'h000;
    bus_path = 1'b1;
    oc_ev = 5'h00;
    adc_code = 8'h00;
    {bad_count, n_compared, cyc, starts} = {32'd0, 32'd0, 32'd0, 32'd0};
    repeat (8) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (4) @(negedge ref_clk);
    check(outs, 8'h08);
    for (int r = 0; r < 8; r++) rd_chk(r[7:0], 8'h00);
    host.wr(7'h44, HPSP_OFS_CTRL_A, 8'h03, acks);
    check({5'h00, acks}, 8'h00);
    check(outs, 8'h08);
    wr(HPSP_OFS_CTRL_A, 8'hff);
    check(outs, 8'hc8);
    for (int g = 0; g < 4; g++) begin
      {a_ag, a_mg, b_ag, b_mg} = {g[1:0], g[1:0]};
      rd_chk(HPSP_OFS_CTRL_A, {g[1:0], 6'h03});
      rd_chk(HPSP_OFS_CTRL_B, {g[1:0], 6'h00});
    end
    wr(HPSP_OFS_CTRL_B, 8'h3e);
    wr(HPSP_OFS_CTRL_A, 8'h01);
    wr(8'h06, 8'hff);
    check(outs, 8'h68);
    rd_chk(HPSP_OFS_CTRL_B, 8'hc2);
    for (int s = 0; s < 4; s++) begin
      {a_mst, a_xst} = s[1:0];
      rd_chk(HPSP_OFS_STAT_A, {1'b0, s[1:0], 5'h00});
    end
    ext_trip_low = 1'b1;
    rd_chk(HPSP_OFS_STAT_A, 8'h60);
    bus_path = 1'b0;
    rd_chk(HPSP_OFS_STAT_A, 8'he0);
    ext_trip_low = 1'b0;
    rd_chk(HPSP_OFS_STAT_A, 8'h60);
    bus_path = 1'b1;
    for (int i = 0; i < 5; i++) begin
      ev(5'h01 << i);
      check(outs, 8'h60);
      rd_chk(HPSP_OFS_STAT_A, 8'h60 | (8'h01 << i));
      wr(HPSP_OFS_STAT_A, 8'he0 | (~(8'h01 << i) & 8'h1f));
      rd_chk(HPSP_OFS_STAT_A, 8'h60 | (8'h01 << i));
      wr(HPSP_OFS_STAT_A, 8'h01 << i);
      rd_chk(HPSP_OFS_STAT_A, 8'h60);
      check(outs, 8'h68);
    end
    ev(5'h18);
    wr(HPSP_OFS_STAT_A, 8'h10);
    check(outs, 8'h60);
    rd_chk(HPSP_OFS_STAT_A, 8'h68);
    wr(HPSP_OFS_STAT_A, 8'h08);
    check(outs, 8'h68);
    {bus_path, on_pin, auxen_pin} = 3'b011;
    ev(5'h04);
    check(outs, 8'h64);
    rd_chk(HPSP_OFS_STAT_A, 8'he4);
    on_pin = 1'b0;
    repeat (3) @(negedge ref_clk);
    check(outs, 8'h60);
    wr(HPSP_OFS_STAT_A, 8'h04);
    {bus_path, auxen_pin} = 2'b10;
    for (int r = 0; r < 6; r++) begin
      adc_code = {5'h06, r[2:0]};
      wr(HPSP_OFS_ADC_CTRL, {3'h4, r[1], r[0], r[2:0]});
      check({adc_rail, adc_qty, adc_slot, 3'h0}, {r[2:0], r[0], r[1], 3'h0});
      rd_chk(HPSP_OFS_ADC_CTRL, {r != 0, 2'b00, r[1], r[0], r[2:0]});
      rd_chk(HPSP_OFS_ADC_CTRL, {3'h0, r[1], r[0], r[2:0]});
      rd_chk(HPSP_OFS_RESULT, (r == 0) ? 8'h00 : {5'h06, r[2:0]});
      check(8'(starts), 8'(r));
    end
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (3) @(negedge ref_clk);
    check(outs, 8'h08);
    rd_chk(HPSP_OFS_CTRL_A, 8'hc0);
    rd_chk(HPSP_OFS_CTRL_B, 8'hc0);
    give_verdict();
  end
endmodule
